// >>> rtl/adc_serial_device.sv
`timescale 1ns/1ps
// What this block does
// R01 - select high at start picks select mode
// R02 - three-wire: select input tied permanently high
// R03 - start edge samples, converts, floats output
// R04 - conversion ignores select line once started
// R05 - three-wire plain: start high at conversion end
// R06 - conversion end powers down into acquisition
// R07 - start fall presents MSB, clock falls shift
// R08 - three-wire plain: host gives fifteen falls; the host here gives sixteen
// R09 - plain: float after sixteenth fall or deselect
// R10 - three-wire busy: start low through conversion
// R11 - busy: drive low busy bit, then MSB
// R12 - three-wire busy: host gives sixteen falls; the host here gives seventeen
// R13 - busy: float after seventeenth fall or deselect
// R14 - four-wire: select high first, start held
// R15 - four-wire plain: select high at end
// R16 - four-wire plain: select fall presents MSB
// R17 - shared line: next device after float
// R18 - four-wire: never both lines low
// R19 - four-wire busy: select low through conversion
// R20 - busy options: pull-up on output line
// R21 - chain mode: shift input through to output
// R22 - result is straight binary sixteen bits
// R23 - host keeps serial clock still converting
// R24 - host counts edges, ignores floating line
module adc_serial_device
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // link
  adc_link_if.device link,
  // user side
  input wire adc_link_pkg::sample_type analog_sample,
  output logic converting,
  output logic powered_down,
  output logic chain_mode
);
  import adc_link_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // link clock domain: toggles on each falling edge and catches the chain input

  typedef struct packed
  {
    logic edge_tgl;
    logic chain_bit;
  } link_state_type;

  link_state_type ln_q;
  link_state_type ln_d;

  always_comb
  begin
    ln_d = ln_q;
    ln_d.edge_tgl = ~ln_q.edge_tgl;
    // chain input latched on every falling edge
    ln_d.chain_bit = link.serial_in_select; // [R21]
  end

  always_ff @(negedge link.link_sclk or negedge resetn)
  begin
    if (!resetn)
    begin
      ln_q <= '0;
    end
    else
    begin
      ln_q <= ln_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // internal clock domain

  typedef struct packed
  {
    dev_state_type state;
    logic [11:0] cnt;
    logic [4:0] edges;
    logic [4:0] limit;
    logic [16:0] sh;
    logic conv_meta;
    logic conv_sync;
    logic conv_prev;
    logic sin_meta;
    logic sin_sync;
    logic sel_prev;
    logic tgl_meta;
    logic tgl_sync;
    logic tgl_prev;
    logic tgl_old;
    logic bit_meta;
    logic bit_sync;
    logic chain;
    logic out_bit;
    logic oe;
    logic converting;
    logic powered_down;
  } dev_reg_type;

  dev_reg_type s_q;
  dev_reg_type s_d;
  logic sel_low;
  logic start_rise;
  logic sclk_fall;

  always_comb
  begin
    s_d = s_q;
    // either line low means selected; the host never drives both low
    sel_low = !s_q.conv_sync || !s_q.sin_sync; // [R09] [R18]
    start_rise = s_q.conv_sync && !s_q.conv_prev;
    // fall taken one stage late so the crossed chain bit has settled
    sclk_fall = s_q.tgl_prev ^ s_q.tgl_old;

    s_d.conv_meta = link.conv_start_select;
    s_d.conv_sync = s_q.conv_meta;
    s_d.conv_prev = s_q.conv_sync;
    s_d.sin_meta = link.serial_in_select;
    s_d.sin_sync = s_q.sin_meta;
    s_d.sel_prev = sel_low;
    s_d.tgl_meta = ln_q.edge_tgl;
    s_d.tgl_sync = s_q.tgl_meta;
    s_d.tgl_prev = s_q.tgl_sync;
    s_d.tgl_old = s_q.tgl_prev;
    s_d.bit_meta = ln_q.chain_bit;
    s_d.bit_sync = s_q.bit_meta;

    // a start edge during conversion is ignored
    if (start_rise && s_q.state != dev_convert) // [R04]
    begin
      // mode strap taken at the start edge
      s_d.chain = !s_q.sin_sync; // [R01]
      // sample the input; output floats, chain mode drives the MSB
      s_d.sh = {analog_sample, 1'b0}; // [R03] [R22]
      s_d.oe = !s_q.sin_sync; // [R03]
      s_d.state = dev_convert;
      s_d.cnt = '0;
      s_d.converting = 1'b1;
      s_d.powered_down = 1'b0;
    end
    else
    begin
      case (s_q.state)
        dev_idle:
        begin
          s_d.oe = s_q.chain && s_q.oe;
        end
        dev_convert:
        begin
          // fixed length, runs whatever the select lines do
          s_d.cnt = s_q.cnt + 12'h001; // [R04]
          if (s_q.cnt == conv_cycles - 12'h001)
          begin
            s_d.converting = 1'b0;
            s_d.powered_down = 1'b1; // [R06]
            s_d.edges = '0;
            if (s_q.chain)
            begin
              s_d.oe = 1'b1; // [R21]
              s_d.state = dev_shift;
            end
            else if (sel_low)
            begin
              // busy bit low first, MSB on the next fall
              s_d.sh = {1'b0, s_q.sh[16:1]}; // [R11]
              s_d.oe = 1'b1; // [R11]
              s_d.limit = edge_limit(1'b1); // [R13]
              s_d.state = dev_shift;
            end
            else
            begin
              s_d.limit = edge_limit(1'b0); // [R09]
              s_d.state = dev_ready;
            end
          end
        end
        dev_ready:
        begin
          // select falling edge presents the MSB
          if (sel_low && !s_q.sel_prev)
          begin
            s_d.oe = 1'b1; // [R07] [R16]
            s_d.state = dev_shift;
          end
        end
        dev_shift:
        begin
          if (!s_q.chain && !sel_low)
          begin
            // deselect floats the output early
            s_d.oe = 1'b0; // [R09] [R13]
            s_d.state = dev_idle;
          end
          else if (sclk_fall)
          begin
            // next lower bit; chain word is sixteen bits, pad dropped
            s_d.sh = s_q.chain ? {s_q.sh[15:1], s_q.bit_sync, 1'b0}
              : {s_q.sh[15:0], s_q.bit_sync}; // [R07] [R21]
            s_d.edges = s_q.edges + 5'h01;
            if (!s_q.chain && s_q.edges + 5'h01 == s_q.limit)
            begin
              s_d.oe = 1'b0; // [R09] [R13]
              s_d.state = dev_idle;
            end
          end
        end
        default:
        begin
          s_d.state = dev_idle;
        end
      endcase
    end
    s_d.out_bit = s_d.sh[16];
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q <= '0;
      s_q.conv_meta <= 1'b1;
      s_q.conv_sync <= 1'b1;
      s_q.conv_prev <= 1'b1;
      s_q.sin_meta <= 1'b1;
      s_q.sin_sync <= 1'b1;
      s_q.powered_down <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign link.serial_out = s_q.out_bit;
  assign link.serial_out_oe = s_q.oe;
  assign converting = s_q.converting;
  assign powered_down = s_q.powered_down;
  assign chain_mode = s_q.chain;

endmodule : adc_serial_device

// >>> inc/adc_link_pkg.sv
package adc_link_pkg;

  //////////////////////////////////////////////////////////////////////////
  // timing
  localparam int clk_period_ns = 10;
  // internal conversion time of the device
  localparam int t_conv_ns = 2000;
  // guaranteed bounds that the host plans against
  localparam int t_conv_min_ns = 1800;
  localparam int t_conv_max_ns = 2200;
  // delay from conversion start to the select drop in busy options
  localparam int t_select_ns = 100;

  localparam logic [11:0] conv_cycles = 12'(t_conv_ns / clk_period_ns);
  localparam logic [11:0] host_wait_cycles =
    12'((t_conv_max_ns + clk_period_ns - 1) / clk_period_ns);
  localparam logic [11:0] select_cycles =
    12'((t_select_ns + clk_period_ns - 1) / clk_period_ns);
  // host serial clock half period in system cycles
  localparam logic [11:0] sclk_half_cycles = 12'h006;

  //////////////////////////////////////////////////////////////////////////
  // data format
  localparam int sample_bits = 16;
  localparam logic [4:0] edges_plain = 5'h10;
  localparam logic [4:0] edges_busy = 5'h11;

  typedef logic [sample_bits-1:0] sample_type;

  typedef enum logic [1:0]
  {
    dev_idle = 2'b00,
    dev_convert = 2'b01,
    dev_ready = 2'b10,
    dev_shift = 2'b11
  } dev_state_type;

  typedef enum logic [1:0]
  {
    host_idle = 2'b00,
    host_conv = 2'b01,
    host_clock = 2'b10,
    host_done = 2'b11
  } host_state_type;

  // falling edges that end one word
  function automatic logic [4:0] edge_limit(input logic busy);
    edge_limit = busy ? edges_busy : edges_plain;
  endfunction : edge_limit

endpackage : adc_link_pkg

// >>> inc/adc_link_if.sv
`timescale 1ns/1ps
interface adc_link_if;

  logic conv_start_select;
  logic serial_in_select;
  logic link_sclk;
  logic serial_out;
  logic serial_out_oe;
  logic serial_line;

  // board pull-up holds the line high while the output floats
  assign serial_line = serial_out_oe ? serial_out : 1'b1; // [R20]

  modport device
  (
    input conv_start_select,
    input serial_in_select,
    input link_sclk,
    output serial_out,
    output serial_out_oe
  );

  modport host
  (
    output conv_start_select,
    output serial_in_select,
    output link_sclk,
    input serial_line
  );

endinterface : adc_link_if

// >>> rtl/adc_serial_host.sv
`timescale 1ns/1ps
module adc_serial_host
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // link
  adc_link_if.host link,
  // user side
  input wire logic start,
  input wire logic four_wire,
  input wire logic busy_bit,
  output logic ready,
  output adc_link_pkg::sample_type result,
  output logic result_valid
);
  import adc_link_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed
  {
    host_state_type state;
    logic [11:0] cnt;
    logic [4:0] edges;
    logic [16:0] sh;
    logic conv;
    logic sel;
    logic sclk;
    logic four;
    logic busy;
    logic line_meta;
    logic line_sync;
    sample_type result;
    logic valid;
    logic ready;
  } host_reg_type;

  host_reg_type h_q;
  host_reg_type h_d;

  always_comb
  begin
    h_d = h_q;
    h_d.valid = 1'b0;
    h_d.line_meta = link.serial_line;
    h_d.line_sync = h_q.line_meta;
    case (h_q.state)
      host_idle:
      begin
        // start low only after select went high a cycle before
        h_d.conv = 1'b0; // [R18]
        h_d.sclk = 1'b0; // [R23]
        if (start)
        begin
          h_d.four = four_wire;
          h_d.busy = busy_bit;
          // select input is already high at the start edge
          h_d.sel = 1'b1; // [R02] [R14]
          h_d.conv = 1'b1; // [R14]
          h_d.cnt = '0;
          h_d.ready = 1'b0;
          h_d.state = host_conv;
        end
      end
      host_conv:
      begin
        // plain options leave the selecting line high until the end
        h_d.cnt = h_q.cnt + 12'h001; // [R05] [R15]
        if (h_q.busy && h_q.cnt == select_cycles)
        begin
          if (h_q.four)
          begin
            h_d.sel = 1'b0; // [R19]
          end
          else
          begin
            h_d.conv = 1'b0; // [R10]
          end
        end
        if (h_q.cnt == host_wait_cycles)
        begin
          h_d.cnt = '0;
          h_d.edges = '0;
          h_d.state = host_clock;
          if (!h_q.busy)
          begin
            if (h_q.four)
            begin
              h_d.sel = 1'b0; // [R16]
            end
            else
            begin
              h_d.conv = 1'b0; // [R07]
            end
          end
        end
      end
      host_clock:
      begin
        h_d.cnt = h_q.cnt + 12'h001;
        if (h_q.cnt == sclk_half_cycles - 12'h001)
        begin
          h_d.cnt = '0;
          h_d.sclk = !h_q.sclk;
          if (h_q.sclk)
          begin
            // line sampled just before each fall; own edge count
            h_d.sh = {h_q.sh[15:0], h_q.line_sync}; // [R24]
            h_d.edges = h_q.edges + 5'h01;
            if (h_q.edges + 5'h01 == edge_limit(h_q.busy)) // [R08] [R12]
            begin
              h_d.state = host_done;
            end
          end
        end
      end
      host_done:
      begin
        h_d.result = h_q.sh[15:0];
        h_d.valid = 1'b1;
        h_d.ready = 1'b1;
        // the device floats a few cycles after the last fall, so the line frees up
        h_d.sel = 1'b1; // [R17]
        h_d.state = host_idle;
      end
      default:
      begin
        h_d.state = host_idle;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      h_q <= '0;
      h_q.sel <= 1'b1;
      h_q.ready <= 1'b1;
      h_q.line_meta <= 1'b1;
      h_q.line_sync <= 1'b1;
    end
    else
    begin
      h_q <= h_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign link.conv_start_select = h_q.conv;
  assign link.serial_in_select = h_q.sel;
  assign link.link_sclk = h_q.sclk;
  assign ready = h_q.ready;
  assign result = h_q.result;
  assign result_valid = h_q.valid;

endmodule : adc_serial_host

// >>> test/adc_link_sva.sv
`timescale 1ns/1ps
module adc_link_sva
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // link
  input wire logic conv_start_select,
  input wire logic serial_in_select,
  input wire logic link_sclk,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic serial_line
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  logic sel_low;
  logic fall;
  logic sclk_q;
  logic [4:0] falls_q;
  logic [7:0] low_q;
  logic [3:0] quiet_q;
  assign sel_low = !conv_start_select || !serial_in_select;
  assign fall = sclk_q && !link_sclk;
  // falls per word, cycles selected, cycles since last fall
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sclk_q <= 1'b0;
      falls_q <= 5'h00;
      low_q <= 8'h00;
      quiet_q <= 4'h0;
    end
    else
    begin
      sclk_q <= link_sclk;
      falls_q <= !serial_out_oe ? 5'h00 : falls_q + 5'(fall);
      low_q <= !sel_low ? 8'h00 : low_q + 8'(low_q != 8'hff);
      quiet_q <= fall ? 4'h0 : quiet_q + 4'(quiet_q != 4'hf);
    end
  end
  //////////////////////////////////////////////////////////////////////////
  property p_start_float;
    $rose(conv_start_select) && serial_in_select
      |-> ##4 (!serial_out_oe)[*8];
  endproperty
  a_start_float: assert property (p_start_float)
    else $error("output driven after start");
  property p_sclk_still;
    $rose(conv_start_select) |=> (!link_sclk)[*8];
  endproperty
  a_sclk_still: assert property (p_sclk_still)
    else $error("serial clock moved at start");
  property p_deselect;
    (conv_start_select && serial_in_select)[*5] |-> !serial_out_oe;
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("output driven while deselected");
  property p_busy_low;
    $rose(serial_out_oe) && low_q > 8'h20 |-> !serial_out;
  endproperty
  a_busy_low: assert property (p_busy_low)
    else $error("busy bit not low");
  property p_bit_hold;
    serial_out_oe && $past(serial_out_oe) && quiet_q > 4'h6
      |-> $stable(serial_out);
  endproperty
  a_bit_hold: assert property (p_bit_hold)
    else $error("bit changed without a clock fall");
  property p_fall_limit;
    falls_q <= 5'h11;
  endproperty
  a_fall_limit: assert property (p_fall_limit)
    else $error("output driven past word end");
  property p_fall_selected;
    $fell(link_sclk) |-> sel_low;
  endproperty
  a_fall_selected: assert property (p_fall_selected)
    else $error("clock fall while deselected");
  property p_not_both_low;
    conv_start_select || serial_in_select;
  endproperty
  a_not_both_low: assert property (p_not_both_low)
    else $error("both select lines low");
  c_busy: cover property ($rose(serial_out_oe) && low_q > 8'h20);
  c_busy_word: cover property (falls_q == 5'h11);
  c_plain_word: cover property ($fell(serial_out_oe) && falls_q == 5'h10);
endmodule : adc_link_sva

// >>> test/sar_adc_serial_readout_bench.sv
`timescale 1ns/1ps
module sar_adc_serial_readout_bench;
  import adc_link_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic start = 1'b0;
  logic four_wire = 1'b0;
  logic busy_bit = 1'b0;
  sample_type sample_a = 16'h0000;
  sample_type sample_b = 16'h0000;
  sample_type result;
  sample_type w;
  sample_type corner [4] = '{16'hffff, 16'h0000, 16'h8000, 16'h7fff};
  logic ready, result_valid, conv_a, pd_a, chain_a, conv_b, pd_b, chain_b;
  int miscompares = 0;
  int cmp_count = 0;
  adc_link_if link_a ();
  adc_link_if link_b ();
  always #5 sys_clk = ~sys_clk;
  adc_serial_host adc_serial_host_inst (.sys_clk(sys_clk),
    .resetn(resetn), .link(link_a), .start(start),
    .four_wire(four_wire), .busy_bit(busy_bit), .ready(ready),
    .result(result), .result_valid(result_valid));
  adc_serial_device adc_serial_device_inst (.sys_clk(sys_clk),
    .resetn(resetn), .link(link_a), .analog_sample(sample_a),
    .converting(conv_a), .powered_down(pd_a), .chain_mode(chain_a));
  // second device driven by the bench
  adc_serial_device adc_serial_device_inst2 (.sys_clk(sys_clk),
    .resetn(resetn), .link(link_b), .analog_sample(sample_b),
    .converting(conv_b), .powered_down(pd_b), .chain_mode(chain_b));
  adc_link_sva adc_link_sva_inst (.sys_clk(sys_clk), .resetn(resetn),
    .conv_start_select(link_a.conv_start_select),
    .serial_in_select(link_a.serial_in_select),
    .link_sclk(link_a.link_sclk), .serial_out(link_a.serial_out),
    .serial_out_oe(link_a.serial_out_oe),
    .serial_line(link_a.serial_line));
  //////////////////////////////////////////////////////////////////////////
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  task check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task end_of_test;
    if (miscompares == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test
  // one host conversion and readout
  task run(input logic fw, input logic bb, input sample_type s);
    int i;
    sample_a <= s;
    four_wire <= fw;
    busy_bit <= bb;
    start <= 1'b1;
    tick(1);
    start <= 1'b0;
    tick(20);
    check(16'(conv_a), 16'h0001);
    check(16'(pd_a), 16'h0000);
    check(16'(ready), 16'h0000);
    for (i = 0; i < 1000 && result_valid !== 1'b1; i++)
      @(negedge sys_clk);
    if (i == 1000)
    begin
      miscompares++;
      end_of_test();
    end
    check(result, s);
    check(16'(pd_a), 16'h0001);
    check(16'(chain_a), 16'h0000);
    check(16'(ready), 16'h0001);
    tick(1);
  endtask : run
  // clock n bits out of the second device, feeding fill msb first
  task bits_b(input int n, input sample_type fill);
    int i;
    w = 16'h0000;
    for (i = 0; i < n; i++)
    begin
      w = {w[14:0], link_b.serial_line};
      link_b.serial_in_select <= fill[15-i];
      link_b.link_sclk <= 1'b1;
      tick(6);
      link_b.link_sclk <= 1'b0;
      tick(6);
    end
  endtask : bits_b
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    sample_type fill;
    link_b.conv_start_select = 1'b0;
    link_b.serial_in_select = 1'b1;
    link_b.link_sclk = 1'b0;
    void'($urandom(23537));
    tick(20);
    resetn <= 1'b1;
    tick(2);
    for (int m = 0; m < 16; m++)
      run(m[3], m[2], corner[m[1:0]]);
    repeat (8)
      run(1'($urandom), 1'($urandom), 16'($urandom));
    // chain mode on the second device
    fill = 16'($urandom);
    link_b.serial_in_select <= 1'b0;
    tick(1);
    link_b.conv_start_select <= 1'b1;
    sample_b <= 16'($urandom);
    tick(10);
    check(16'(chain_b), 16'h0001);
    check(16'(link_b.serial_out_oe), 16'h0001);
    tick(220);
    bits_b(16, fill);
    check(w, sample_b);
    bits_b(16, 16'h0000);
    check(w, fill);
    // three-wire plain, select toggled in conversion, early deselect
    link_b.serial_in_select <= 1'b1;
    tick(1);
    link_b.conv_start_select <= 1'b0;
    tick(4);
    link_b.conv_start_select <= 1'b1;
    sample_b <= 16'($urandom);
    tick(10);
    check(16'(chain_b), 16'h0000);
    check(16'(link_b.serial_out_oe), 16'h0000);
    link_b.conv_start_select <= 1'b0;
    tick(20);
    link_b.conv_start_select <= 1'b1;
    check(16'(conv_b), 16'h0001);
    tick(200);
    check(16'(pd_b), 16'h0001);
    link_b.conv_start_select <= 1'b0;
    tick(6);
    check(16'(link_b.serial_out_oe), 16'h0001);
    bits_b(4, 16'hffff);
    check({12'h000, w[3:0]}, {12'h000, sample_b[15:12]});
    link_b.conv_start_select <= 1'b1;
    tick(6);
    check(16'(link_b.serial_out_oe), 16'h0000);
    end_of_test();
  end
endmodule : sar_adc_serial_readout_bench
